/* File: verilog/dwp_cfg.svh */
`ifndef DWP_CFG_SVH
`define DWP_CFG_SVH
// Command codes, low two bits of the written byte
`define DWP_CMD_CLEAR 2'h0
`define DWP_CMD_START 2'h1
`define DWP_CMD_RESET 2'h2
`define DWP_CMD_RSVD 2'h3
// Full command byte sent after a reset
`define DWP_BYTE_CLEAR 8'h00
// Wake-up block layout
`define DWP_WAKE_LEN 3'h6
`define DWP_WAKE_OFS_LO 3'h2
`define DWP_WAKE_OFS_HI 3'h3
`define DWP_WAKE_SEG_LO 3'h4
`define DWP_WAKE_SEG_HI 3'h5
// Segment shift that turns the port value into a memory address
`define DWP_SEG_SHIFT 4
// Offset of the status byte from the saved block address
`define DWP_STATUS_OFS 20'h00001
// Reset values
`define DWP_RST_ADDR 20'h00000
`define DWP_RST_BYTE 8'h00
`endif

/* File: verilog/dwp_pkg.sv */
package dwp_pkg;
    typedef enum logic [2:0] {
        DWP_D_IDLE = 3'h0,
        DWP_D_FETCH = 3'h1,
        DWP_D_RUN = 3'h3,
        DWP_D_POST = 3'h2
    } dwp_dev_state_e;
    typedef enum logic [1:0] {
        DWP_H_IDLE = 2'h0,
        DWP_H_WR = 2'h1,
        DWP_H_CLR = 2'h3
    } dwp_host_state_e;
    typedef logic [19:0] dwp_maddr_t;
    typedef logic [15:0] dwp_port_t;
    typedef logic [7:0] dwp_byte_t;
endpackage

/* File: verilog/dwp_bus_if.sv */
`timescale 1ns/1ps
interface dwp_bus_if;
    import dwp_pkg::*;
    // Host I/O and memory cycles on the shared bus
    logic io_wr;
    logic io_rd;
    logic mem_cyc;
    logic io_wide;
    dwp_port_t addr;
    dwp_byte_t data;
    // Board to host
    logic irq;
    // Board as bus master, one byte per request
    logic dma_req;
    logic dma_we;
    dwp_maddr_t dma_addr;
    dwp_byte_t dma_wdata;
    logic dma_ack;
    dwp_byte_t dma_rdata;
    modport dev (
        input io_wr, io_rd, mem_cyc, io_wide, addr, data, dma_ack, dma_rdata,
        output irq, dma_req, dma_we, dma_addr, dma_wdata
    );
    modport host (
        output io_wr, io_rd, mem_cyc, io_wide, addr, data, dma_ack, dma_rdata,
        input irq, dma_req, dma_we, dma_addr, dma_wdata
    );
endinterface

/* File: verilog/dwp_host.sv */
`timescale 1ns/1ps
`include "dwp_cfg.svh"
module dwp_host
    import dwp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    dwp_bus_if.host bus,
    input wire logic cmd_req,
    input wire dwp_byte_t cmd_byte,
    input wire dwp_port_t cmd_port,
    input wire logic cmd_wide,
    output logic cmd_ack,
    output logic cmd_refused,
    output logic busy,
    output logic link_lost,
    output logic irq_seen,
    output logic mem_req,
    output logic mem_we,
    output dwp_maddr_t mem_addr,
    output dwp_byte_t mem_wdata,
    input wire logic mem_ack,
    input wire dwp_byte_t mem_rdata
);
    dwp_host_state_e state_q;
    dwp_byte_t data_q;
    dwp_port_t port_q;
    logic wide_q;
    logic busy_q;
    logic lost_q;
    logic is_start;
    logic accept;

    assign is_start = cmd_byte[1:0] == `DWP_CMD_START;
    // One storage operation in flight at a time
    assign accept = cmd_req && state_q == DWP_H_IDLE && !(is_start && busy_q); // RL14
    assign cmd_refused = cmd_req && state_q == DWP_H_IDLE && is_start && busy_q;
    assign cmd_ack = state_q == DWP_H_WR;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DWP_H_IDLE;
        end else begin
            case (state_q)
                DWP_H_IDLE: begin
                    if (accept) begin
                        state_q <= DWP_H_WR; // RL12
                    end
                end
                DWP_H_WR: begin
                    if (data_q[1:0] == `DWP_CMD_RESET) begin
                        state_q <= DWP_H_CLR; // RL9
                    end else begin
                        state_q <= DWP_H_IDLE;
                    end
                end
                DWP_H_CLR: state_q <= DWP_H_IDLE;
                default: state_q <= DWP_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= `DWP_RST_BYTE;
            port_q <= 16'h0000;
            wide_q <= 1'b0;
        end else if (accept) begin
            data_q <= cmd_byte;
            port_q <= cmd_port;
            wide_q <= cmd_wide;
        end else if (state_q == DWP_H_WR && data_q[1:0] == `DWP_CMD_RESET) begin
            data_q <= `DWP_BYTE_CLEAR; // RL9
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (accept && cmd_byte[1:0] == `DWP_CMD_RESET) begin
            busy_q <= 1'b0;
        end else if (accept && is_start) begin
            busy_q <= 1'b1; // RL14
        end else if (bus.irq) begin
            busy_q <= 1'b0;
        end
    end

    // Link counts as lost from each reset until the next start re-inits it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lost_q <= 1'b1;
        end else if (accept && cmd_byte[1:0] == `DWP_CMD_RESET) begin
            lost_q <= 1'b1; // RL10
        end else if (accept && is_start) begin
            lost_q <= 1'b0;
        end
    end

    assign bus.io_wr = state_q == DWP_H_WR || state_q == DWP_H_CLR;
    assign bus.io_rd = 1'b0;
    assign bus.mem_cyc = 1'b0;
    assign bus.io_wide = wide_q;
    assign bus.addr = port_q;
    assign bus.data = data_q;
    assign busy = busy_q;
    assign link_lost = lost_q;
    assign irq_seen = bus.irq;
    // Board DMA goes to system memory; blocks lie in the 20-bit space
    assign mem_req = bus.dma_req; // RL13
    assign mem_we = bus.dma_we;
    assign mem_addr = bus.dma_addr;
    assign mem_wdata = bus.dma_wdata;
    assign bus.dma_ack = mem_ack;
    assign bus.dma_rdata = mem_rdata;
endmodule

/* File: verilog/dwp_dev.sv */
`timescale 1ns/1ps
`include "dwp_cfg.svh"
// Functional notes
// [RL1] One jumper port address, 8 or 16 bits
// [RL2] Jumper picks qualifier governing decode width
// [RL3] Wake-up address is port value shifted four
// [RL4] Only low two command bits decoded
// [RL5] Only I/O writes to port are recognised
// [RL6] Code 00 clears interrupt and board reset
// [RL7] Code 01 starts prepared storage operation
// [RL8] Code 02 hard-resets the board logic
// [RL9] Host follows reset with clear-interrupt
// [RL10] Every reset loses link; reinitialise first
// [RL11] Board is bus master, never system master
// [RL12] Start by port byte, then memory blocks
// [RL13] Host places four blocks, 68 bytes
// [RL14] Host interlocks: one operation at a time
// [RL15] First start fetches wake-up block, saves pointer
// [RL16] On finish post status, interrupt, wait
// [RL17] Code 03 is reserved and ignored
// [RL18] Interrupt held until clear-interrupt command; a reset command also clears it
module dwp_dev
    import dwp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    dwp_bus_if.dev bus,
    input wire dwp_port_t jmp_port,
    input wire logic jmp_dec16,
    input wire logic jmp_qual_sel,
    output logic op_start,
    output dwp_maddr_t op_block_addr,
    input wire logic op_done,
    input wire dwp_byte_t op_status,
    output logic board_reset,
    output logic link_up,
    output dwp_maddr_t wake_addr
);
    dwp_port_t port_m;
    dwp_port_t port_s;
    logic dec16_m;
    logic dec16_s;
    logic qual_m;
    logic qual_s;
    logic wide;
    logic addr_hit;
    logic hit;
    logic cmd_clear;
    logic cmd_start;
    logic cmd_reset;
    logic fetch_last;
    logic post_done;
    dwp_dev_state_e state_q;
    logic [2:0] idx_q;
    dwp_byte_t ofs_lo_q;
    dwp_byte_t ofs_hi_q;
    dwp_byte_t seg_lo_q;
    dwp_maddr_t block_q;
    logic link_q;
    logic rst_hold_q;
    logic irq_q;
    logic start_q;
    dwp_byte_t status_q;
    dwp_maddr_t seg_addr;

    // Jumpers are pins: two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_m <= 16'h0000;
            port_s <= 16'h0000;
            dec16_m <= 1'b0;
            dec16_s <= 1'b0;
            qual_m <= 1'b0;
            qual_s <= 1'b0;
        end else begin
            port_m <= jmp_port;
            port_s <= port_m;
            dec16_m <= jmp_dec16;
            dec16_s <= dec16_m;
            qual_m <= jmp_qual_sel;
            qual_s <= qual_m;
        end
    end

    // Width from the bus qualifier or from the fixed width jumper
    assign wide = qual_s ? bus.io_wide : dec16_s; // RL2
    assign addr_hit = wide ? (bus.addr == port_s) : (bus.addr[7:0] == port_s[7:0]); // RL1
    // Reads and memory cycles never decode
    assign hit = bus.io_wr && !bus.io_rd && !bus.mem_cyc && addr_hit; // RL5
    assign cmd_clear = hit && bus.data[1:0] == `DWP_CMD_CLEAR; // RL4
    assign cmd_start = hit && bus.data[1:0] == `DWP_CMD_START;
    assign cmd_reset = hit && bus.data[1:0] == `DWP_CMD_RESET; // RL17
    // Code 03 matches none of the three and falls through

    assign wake_addr = {port_s, 4'h0}; // RL3

    assign fetch_last = state_q == DWP_D_FETCH && bus.dma_ack
        && idx_q == `DWP_WAKE_LEN - 3'h1;
    assign post_done = state_q == DWP_D_POST && bus.dma_ack;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DWP_D_IDLE;
        end else if (cmd_reset) begin
            state_q <= DWP_D_IDLE; // RL8
        end else begin
            case (state_q)
                DWP_D_IDLE: begin
                    if (cmd_start && !rst_hold_q) begin
                        if (link_q) begin
                            state_q <= DWP_D_RUN; // RL7
                        end else begin
                            state_q <= DWP_D_FETCH; // RL15
                        end
                    end
                end
                DWP_D_FETCH: begin
                    if (fetch_last) begin
                        state_q <= DWP_D_RUN;
                    end
                end
                DWP_D_RUN: begin
                    if (op_done) begin
                        state_q <= DWP_D_POST; // RL16
                    end
                end
                DWP_D_POST: begin
                    if (post_done) begin
                        state_q <= DWP_D_IDLE;
                    end
                end
                default: state_q <= DWP_D_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 3'h0;
        end else if (state_q != DWP_D_FETCH || cmd_reset) begin
            idx_q <= 3'h0;
        end else if (bus.dma_ack) begin
            idx_q <= idx_q + 3'h1;
        end
    end

    // Pointer bytes of the wake-up block
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_lo_q <= `DWP_RST_BYTE;
            ofs_hi_q <= `DWP_RST_BYTE;
            seg_lo_q <= `DWP_RST_BYTE;
        end else if (state_q == DWP_D_FETCH && bus.dma_ack) begin
            case (idx_q)
                `DWP_WAKE_OFS_LO: ofs_lo_q <= bus.dma_rdata;
                `DWP_WAKE_OFS_HI: ofs_hi_q <= bus.dma_rdata;
                `DWP_WAKE_SEG_LO: seg_lo_q <= bus.dma_rdata;
                default: ofs_lo_q <= ofs_lo_q;
            endcase
        end
    end

    assign seg_addr = {bus.dma_rdata, seg_lo_q, 4'h0};

    // Saved next-block address, reused by later starts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            block_q <= `DWP_RST_ADDR;
        end else if (fetch_last) begin
            block_q <= seg_addr + {4'h0, ofs_hi_q, ofs_lo_q}; // RL15
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_q <= 1'b0;
        end else if (cmd_reset) begin
            link_q <= 1'b0; // RL10
        end else if (fetch_last) begin
            link_q <= 1'b1;
        end
    end

    // Board stays held after a reset command until clear-interrupt
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_hold_q <= 1'b0;
        end else if (cmd_reset) begin
            rst_hold_q <= 1'b1; // RL8
        end else if (cmd_clear) begin
            rst_hold_q <= 1'b0; // RL6
        end
    end

    // Set wins over clear-interrupt in the same cycle; a reset command wins over set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (post_done && !cmd_reset) begin
            irq_q <= 1'b1; // RL16
        end else if (cmd_clear || cmd_reset) begin
            irq_q <= 1'b0; // RL18
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= !cmd_reset && ((state_q == DWP_D_IDLE && cmd_start && !rst_hold_q
                && link_q) || fetch_last); // RL7
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `DWP_RST_BYTE;
        end else if (state_q == DWP_D_RUN && op_done) begin
            status_q <= op_status;
        end
    end

    // Only memory requests leave the board; it never writes I/O
    assign bus.dma_req = state_q == DWP_D_FETCH || state_q == DWP_D_POST; // RL11
    assign bus.dma_we = state_q == DWP_D_POST;
    assign bus.dma_addr = (state_q == DWP_D_POST) ? block_q + `DWP_STATUS_OFS
        : wake_addr + {17'h00000, idx_q};
    assign bus.dma_wdata = status_q;
    assign bus.irq = irq_q;
    assign op_start = start_q;
    assign op_block_addr = block_q;
    assign board_reset = rst_hold_q;
    assign link_up = link_q;
endmodule

/* File: testbench/dwp_asserts.sv */
`timescale 1ns/1ps
module dwp_asserts
    import dwp_pkg::*;
#(
    parameter dwp_port_t PORT = 16'h0100
) (
    input logic mclk,
    input logic rst_n,
    input logic io_wr,
    input dwp_port_t addr,
    input dwp_byte_t data,
    input logic irq,
    input logic dma_req,
    input logic dma_we,
    input dwp_maddr_t dma_addr,
    input logic dma_ack
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic hit;
    logic post;
    assign hit = io_wr && addr == PORT;
    assign post = dma_ack && dma_we;
    AST_CLR_IRQ: assert property (hit && data[1:0] == 2'h0 && !post |=> !irq)
        else $error("irq not cleared");
    AST_RST_IRQ: assert property (hit && data[1:0] == 2'h2 |=> !irq)
        else $error("irq survives reset command");
    AST_IRQ_HOLD: assert property (irq && !io_wr |=> irq)
        else $error("irq dropped without command");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(post))
        else $error("irq raised before status post");
    AST_POST: assert property (post && !(io_wr && data[1:0] == 2'h2) |=> irq)
        else $error("no irq after status post");
    AST_REQ_HOLD: assert property (dma_req && !dma_ack && !io_wr |=>
        dma_req && $stable(dma_addr) && $stable(dma_we))
        else $error("memory request changed before ack");
    AST_FETCH: assert property (!dma_req && !io_wr |=>
        !(dma_req && !dma_we && dma_addr[3:0] == 4'h0))
        else $error("fetch started without port write");
    AST_RSVD: assert property (hit && data[1:0] == 2'h3 && !dma_req |=> !dma_req || dma_we)
        else $error("reserved code acted on");
    cover property (hit && data[1:0] == 2'h1);
    cover property (post);
    cover property ($fell(irq));
endmodule

/* File: testbench/disk_controller_wakeup_port_test.sv */
`timescale 1ns/1ps
module disk_controller_wakeup_port_test;
    import dwp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_req = 1'b0, cmd_wide = 1'b0, jmp_dec16 = 1'b1, jmp_qual_sel = 1'b0;
    logic op_done = 1'b0, mem_ack = 1'b0;
    logic cmd_ack, cmd_refused, busy, link_lost, irq_seen, mem_req, mem_we;
    logic op_start, board_reset, link_up;
    dwp_byte_t cmd_byte = 8'h00, mem_rdata = 8'h00, op_status = 8'h00, mem_wdata, wd;
    dwp_port_t cmd_port = 16'h0000, jmp_port = 16'h0100;
    dwp_maddr_t mem_addr, op_block_addr, wake_addr, wa;
    int n_errors = 0, n_tests = 0;
    logic [19:0] n_rd = 20'h00000;
    dwp_bus_if dwp_bus_if_inst ();
    dwp_host dwp_host_inst (.mclk(mclk), .rst_n(rst_n), .bus(dwp_bus_if_inst),
        .cmd_req(cmd_req), .cmd_byte(cmd_byte), .cmd_port(cmd_port), .cmd_wide(cmd_wide),
        .cmd_ack(cmd_ack), .cmd_refused(cmd_refused), .busy(busy), .link_lost(link_lost),
        .irq_seen(irq_seen), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    dwp_dev dwp_dev_inst (.mclk(mclk), .rst_n(rst_n), .bus(dwp_bus_if_inst),
        .jmp_port(jmp_port), .jmp_dec16(jmp_dec16), .jmp_qual_sel(jmp_qual_sel),
        .op_start(op_start), .op_block_addr(op_block_addr), .op_done(op_done),
        .op_status(op_status), .board_reset(board_reset), .link_up(link_up),
        .wake_addr(wake_addr));
    dwp_asserts dwp_asserts_inst (.mclk(mclk), .rst_n(rst_n),
        .io_wr(dwp_bus_if_inst.io_wr), .addr(dwp_bus_if_inst.addr),
        .data(dwp_bus_if_inst.data), .irq(dwp_bus_if_inst.irq),
        .dma_req(dwp_bus_if_inst.dma_req), .dma_we(dwp_bus_if_inst.dma_we),
        .dma_addr(dwp_bus_if_inst.dma_addr), .dma_ack(dwp_bus_if_inst.dma_ack));
    always #50 mclk = ~mclk;
    // Host memory: wake-up block at 01000h points to 02034h
    always @(posedge mclk) begin
        mem_ack <= mem_req && !mem_ack;
        case (mem_addr[2:0])
            3'h0: mem_rdata <= 8'h01;
            3'h2: mem_rdata <= 8'h34;
            3'h5: mem_rdata <= 8'h02;
            default: mem_rdata <= 8'h00;
        endcase
        if (mem_req && !mem_ack && !mem_we) n_rd <= n_rd + 20'h00001;
        if (mem_req && !mem_ack && mem_we) begin
            wa <= mem_addr;
            wd <= mem_wdata;
        end
    end
    task chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task test_done;
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task send(input dwp_byte_t b, input dwp_port_t p, input logic w);
        repeat (3) @(posedge mclk);
        cmd_req <= 1'b1;
        cmd_byte <= b;
        cmd_port <= p;
        cmd_wide <= w;
        for (int k = 0; k < 20; k++) begin
            @(negedge mclk);
            if (cmd_ack === 1'b1) break;
        end
        @(posedge mclk);
        cmd_req <= 1'b0;
    endtask
    task wait_start;
        for (int k = 0; k < 60; k++) begin
            @(negedge mclk);
            if (op_start === 1'b1) break;
        end
    endtask
    task fin(input dwp_byte_t s);
        @(posedge mclk);
        op_status <= s;
        op_done <= 1'b1;
        @(posedge mclk);
        op_done <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            @(negedge mclk);
            if (irq_seen === 1'b1) break;
        end
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk("link_lost", link_lost, 1'b1);
        repeat (3) @(negedge mclk);
        chk("wake_addr", wake_addr, 20'h01000);
        send(8'hff, 16'h0100, 1'b0);
        send(8'h01, 16'hff00, 1'b0);
        // A missed start still marks the host busy; a missed reset frees it
        send(8'h02, 16'hff00, 1'b0);
        jmp_qual_sel <= 1'b1;
        send(8'h01, 16'hff00, 1'b1);
        send(8'h02, 16'hff00, 1'b1);
        repeat (4) @(negedge mclk);
        chk("board_reset", board_reset, 1'b0);
        chk("link_up", link_up, 1'b0);
        chk("reads", n_rd, 20'h0);
        send(8'hfd, 16'hff00, 1'b0);
        wait_start;
        chk("op_start", op_start, 1'b1);
        chk("block", op_block_addr, 20'h02034);
        chk("link_up", link_up, 1'b1);
        chk("reads", n_rd, 20'h6);
        @(posedge mclk);
        cmd_req <= 1'b1;
        cmd_byte <= 8'h01;
        @(negedge mclk);
        chk("refused", cmd_refused, 1'b1);
        @(posedge mclk);
        cmd_req <= 1'b0;
        fin(8'ha5);
        chk("post addr", wa, 20'h02035);
        chk("status", wd, 8'ha5);
        repeat (5) @(negedge mclk);
        chk("irq held", irq_seen, 1'b1);
        chk("busy", busy, 1'b0);
        send(8'h00, 16'h0100, 1'b0);
        @(negedge mclk);
        chk("irq", irq_seen, 1'b0);
        send(8'h01, 16'h0100, 1'b0);
        wait_start;
        chk("op_start", op_start, 1'b1);
        chk("reads", n_rd, 20'h6);
        fin(8'h3c);
        send(8'h02, 16'h0100, 1'b0);
        @(negedge mclk);
        chk("board_reset", board_reset, 1'b1);
        chk("irq", irq_seen, 1'b0);
        @(negedge mclk);
        chk("board_reset", board_reset, 1'b0);
        chk("link_up", link_up, 1'b0);
        chk("link_lost", link_lost, 1'b1);
        send(8'h01, 16'h0100, 1'b0);
        wait_start;
        chk("reads", n_rd, 20'hc);
        test_done;
    end
endmodule
